// file: verilog/lvds_host_pkg.sv
package lvds_host_pkg;

	// ==========================================
	// Bus geometry
	localparam int BUS_W      = 12;
	localparam int NUM_BUS    = 4;
	localparam int APB_AW     = 8;
	localparam int APB_DW     = 32;
	localparam int DLY_W      = 5;

	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_PERIOD  = 8'h04;
	localparam logic [7:0] OFF_WIDTH   = 8'h08;
	localparam logic [7:0] OFF_DELAY   = 8'h0c;
	localparam logic [7:0] OFF_STEP    = 8'h10;
	localparam logic [7:0] OFF_STATUS  = 8'h14;
	localparam logic [7:0] OFF_PATTERN = 8'h18;

	// ==========================================
	// Control fields
	localparam int CTRL_EN     = 0;
	localparam int CTRL_MODE   = 1;
	localparam int CTRL_LSB    = 3;
	localparam int CTRL_REGSEL = 4;
	localparam int CTRL_DCM    = 5;
	localparam int CTRL_STROBE = 6;
	localparam int CTRL_CONST  = 7;
	localparam int CTRL_W      = 8;

	// ==========================================
	// Status fields
	localparam int STAT_SEEN   = 0;
	localparam int STAT_ALARM  = 1;
	localparam int STAT_SWITCH = 2;

	// ==========================================
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST    = 8'h00;
	localparam logic [7:0]        PERIOD_RST  = 8'h01;
	localparam logic [3:0]        WIDTH_RST   = 4'hc;
	localparam logic [BUS_W-1:0]  PATTERN_RST = 12'h000;
	localparam logic [DLY_W-1:0]  DELAY_RST   = 5'h00;

	// ==========================================
	// Interface modes
	typedef logic [1:0] mode_t;
	localparam mode_t ONE_BUS_PER_CHANNEL     = 2'h0;
	localparam mode_t TWO_BUS_PER_CHANNEL     = 2'h1;
	localparam mode_t FOUR_BUS_SINGLE_CHANNEL = 2'h2;

	// ==========================================
	// Delay ranges
	localparam logic [DLY_W-1:0] DLY_MAX_FOUR = 5'h1f;
	localparam logic [DLY_W-1:0] DLY_MAX_TWO  = 5'h0f;
	localparam logic [DLY_W-1:0] DLY_MAX_ONE  = 5'h07;

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int LINK_HALF_NS   = 20;
	localparam int LINK_HALF_CYC  = (LINK_HALF_NS * 1000) / CLK_PERIOD_PS;
	localparam int STROBE_GRAIN   = 4;
	localparam int SWITCH_CLKS    = 4;
	localparam logic [3:0] SWITCH_HALVES = 4'h8;

endpackage

// file: verilog/lvds_bus_driver.sv
`timescale 1ns/1ps
module lvds_bus_driver
	import lvds_host_pkg::*;
#(
	parameter int WIDTH = 12
)(
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic             tick,
	input  wire logic             risingEdge,
	input  wire logic             enable,
	input  wire logic [WIDTH-1:0] sample,
	input  wire logic [3:0]       lsbIdx,
	input  wire logic             lsbMode,
	input  wire logic             lsbZero,
	input  wire logic             strobeOnLsb,
	input  wire logic             strobeNow,
	output logic                  busClk,
	output logic [WIDTH-1:0]      busData,
	output logic                  busStrobe
);
	// ==========================================
	// Lane shaping
	wire logic [WIDTH-1:0] laneMask = WIDTH'(1) << lsbIdx;
	wire logic             strobeHere = risingEdge & strobeNow;
	wire logic [WIDTH-1:0] cleared = lsbZero ? (sample & ~laneMask) : sample;
	wire logic [WIDTH-1:0] dataNext = (strobeOnLsb & strobeHere) ? (cleared | laneMask) : cleared;

	// ==========================================
	// Edge-aligned outputs
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			busClk    <= 1'b0;
			busData   <= '0;
			busStrobe <= 1'b0;
		end
		// Disabled bus parks low at once, not at the next tick
		else if (tick || !enable)
		begin
			busClk    <= enable & risingEdge;
			busData   <= enable ? dataNext : '0;
			busStrobe <= enable & strobeHere & ~lsbMode;
		end
		// Dedicated lane quiet by the time the sync pin drops
		else if (lsbMode)
			busStrobe <= 1'b0;
	end
endmodule

// file: verilog/lvds_host_ctrl.sv
`timescale 1ns/1ps
module lvds_host_ctrl
#(
	parameter int LINK_HALF = lvds_host_pkg::LINK_HALF_CYC
)(
	input  wire logic                                sys_clk,
	input  wire logic                                reset,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [lvds_host_pkg::APB_AW-1:0]    paddr,
	input  wire logic [lvds_host_pkg::APB_DW-1:0]    pwdata,
	output logic [lvds_host_pkg::APB_DW-1:0]         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire logic                                alarmPin,
	output logic [lvds_host_pkg::NUM_BUS-1:0]        busClk,
	output logic [lvds_host_pkg::NUM_BUS*lvds_host_pkg::BUS_W-1:0] busData,
	output logic [lvds_host_pkg::NUM_BUS-1:0]        busStrobe,
	output logic                                     syncPin,
	output logic [lvds_host_pkg::DLY_W-1:0]          fifoReadDelay
);
	import lvds_host_pkg::*;

	if (LINK_HALF < 1)
	begin : g_check
		$error("LINK_HALF must be at least one cycle");
	end

	// ==========================================
	// Helper functions
	function automatic logic busOn(input mode_t m, input int k);
		busOn = (m == ONE_BUS_PER_CHANNEL) ? (k == 0 || k == 2) : (m == TWO_BUS_PER_CHANNEL || m == FOUR_BUS_SINGLE_CHANNEL);
	endfunction

	function automatic logic [BUS_W-1:0] laneOffset(input mode_t m, input int k);
		logic [1:0] kk;
		kk = 2'(k);
		if (m == FOUR_BUS_SINGLE_CHANNEL)
			laneOffset = BUS_W'(kk);
		else if (m == TWO_BUS_PER_CHANNEL)
			laneOffset = BUS_W'(kk[0]);
		else
			laneOffset = '0;
	endfunction

	// ==========================================
	// Registers
	logic [CTRL_W-1:0] ctrlReg;
	logic [7:0]        periodReg;
	logic [3:0]        widthReg;
	logic [BUS_W-1:0]  patternReg;
	logic [DLY_W-1:0]  delayReg;
	logic              alarmMeta;
	logic              alarmSync;
	logic              alarmSeenReg;
	logic [CTRL_W-1:0] ctrlNext;
	logic [APB_DW-1:0] rdataNext;
	logic [3:0]        guardCnt;
	wire logic         guardActive = guardCnt != '0;

	assign fifoReadDelay = delayReg;

	wire logic  enCfg     = ctrlReg[CTRL_EN];
	wire mode_t modeCfg   = ctrlReg[CTRL_MODE +: 2];
	wire logic  lsbCfg    = ctrlReg[CTRL_LSB];
	wire logic  regSelCfg = ctrlReg[CTRL_REGSEL];
	wire logic  dcmCfg    = ctrlReg[CTRL_DCM];
	wire logic  strobeCfg = ctrlReg[CTRL_STROBE];
	wire logic  constCfg  = ctrlReg[CTRL_CONST];

	// ==========================================
	// APB decode
	wire logic setup    = psel & ~penable;
	wire logic access   = psel & penable & pready;
	wire logic wrEn     = access & pwrite;
	wire logic hitCtrl  = paddr == OFF_CTRL;
	wire logic hitPer   = paddr == OFF_PERIOD;
	wire logic hitWidth = paddr == OFF_WIDTH;
	wire logic hitDly   = paddr == OFF_DELAY;
	wire logic hitStep  = paddr == OFF_STEP;
	wire logic hitStat  = paddr == OFF_STATUS;
	wire logic hitPat   = paddr == OFF_PATTERN;
	wire logic mapped   = hitCtrl | hitPer | hitWidth | hitDly | hitStep | hitStat | hitPat;

	// Delay range follows mode and 2xRF
	wire logic [DLY_W-1:0] dlyMax = (modeCfg == FOUR_BUS_SINGLE_CHANNEL) ? DLY_MAX_FOUR :
		(modeCfg == TWO_BUS_PER_CHANNEL || dcmCfg) ? DLY_MAX_TWO : DLY_MAX_ONE;
	// Counter-clockwise after an alarm, clockwise otherwise
	wire logic [DLY_W-1:0] dlyDown = (delayReg == '0) ? dlyMax : delayReg - 1'b1;
	wire logic [DLY_W-1:0] dlyUp   = (delayReg >= dlyMax) ? '0 : delayReg + 1'b1;
	wire logic [DLY_W-1:0] dlyStep = alarmSeenReg ? dlyDown : dlyUp;
	// Mode change must not leave the delay out of range
	wire logic [DLY_W-1:0] dlyClamp = delayReg & dlyMax;
	wire logic [3:0] widthEff = (widthReg == 4'h0 || widthReg > 4'hc) ? 4'hc : widthReg;
	wire logic [3:0] lsbIdx   = 4'hc - widthEff;

	always_comb
	begin
		rdataNext = '0;
		if (hitCtrl)
			rdataNext[CTRL_W-1:0] = ctrlReg;
		else if (hitPer)
			rdataNext[7:0] = periodReg;
		else if (hitWidth)
			rdataNext[3:0] = widthReg;
		else if (hitDly)
			rdataNext[DLY_W-1:0] = delayReg;
		else if (hitStat)
			rdataNext[STAT_SWITCH:0] = {guardActive, alarmSync, alarmSeenReg};
		else if (hitPat)
			rdataNext[BUS_W-1:0] = patternReg;
	end

	assign ctrlNext = pwdata[CTRL_W-1:0];

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= setup & ~pwrite ? rdataNext : '0;
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			ctrlReg    <= CTRL_RST;
			periodReg  <= PERIOD_RST;
			widthReg   <= WIDTH_RST;
			patternReg <= PATTERN_RST;
		end
		else if (wrEn)
		begin
			if (hitCtrl)
				ctrlReg <= ctrlNext;
			if (hitPer)
				periodReg <= pwdata[7:0];
			if (hitWidth)
				widthReg <= pwdata[3:0];
			if (hitPat)
				patternReg <= pwdata[BUS_W-1:0];
		end
	end

	// ==========================================
	// Delay stepper and alarm watch
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			alarmMeta    <= 1'b0;
			alarmSync    <= 1'b0;
			alarmSeenReg <= 1'b0;
			delayReg     <= DELAY_RST;
		end
		else
		begin
			alarmMeta <= alarmPin;
			alarmSync <= alarmMeta;
			// New alarm in the step cycle survives the clear
			if (wrEn & hitStep)
				alarmSeenReg <= alarmSync;
			else if (alarmSync)
				alarmSeenReg <= 1'b1;
			if (wrEn & hitStep)
				delayReg <= dlyStep;
			else if (wrEn & hitDly)
				delayReg <= pwdata[DLY_W-1:0] & dlyMax;
			else
				delayReg <= dlyClamp;
		end
	end

	// ==========================================
	// Link clock divider, shared by all buses
	logic [15:0] halfCnt;
	logic        linkPhase;
	wire logic   halfTick   = enCfg && (halfCnt == 16'(LINK_HALF - 1));
	wire logic   risingEdge = ~linkPhase;

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			halfCnt   <= '0;
			linkPhase <= 1'b0;
		end
		else if (!enCfg)
		begin
			halfCnt   <= '0;
			linkPhase <= 1'b0;
		end
		else
		begin
			halfCnt <= halfTick ? '0 : halfCnt + 1'b1;
			if (halfTick)
				linkPhase <= ~linkPhase;
		end
	end

	// ==========================================
	// Strobe timer, common to every bus
	logic [9:0] strobeCnt;
	wire logic [9:0] strobeLast = (periodReg == 8'h00) ? 10'(STROBE_GRAIN - 1) :
		10'({periodReg, 2'b00} - 10'h001);
	wire logic strobeNow = strobeCfg && (strobeCnt == '0);

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			strobeCnt <= '0;
		else if (!strobeCfg)
			strobeCnt <= '0;
		else if (halfTick & risingEdge)
			strobeCnt <= (strobeCnt >= strobeLast) ? '0 : strobeCnt + 1'b1;
	end

	// ==========================================
	// LSB strobe switch-over guard
	logic       lsbPrev;
	wire logic  lsbZero     = guardActive | lsbCfg;
	wire logic  strobeOnLsb = lsbCfg & ~guardActive;

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			lsbPrev  <= 1'b0;
			guardCnt <= '0;
			syncPin  <= 1'b1;
		end
		else
		begin
			lsbPrev <= lsbCfg;
			if (lsbPrev != lsbCfg)
				guardCnt <= SWITCH_HALVES;
			else if (halfTick && guardActive)
				guardCnt <= guardCnt - 1'b1;
			// Register-selected LSB strobe needs the sync pin parked high
			syncPin <= regSelCfg | ~lsbCfg;
		end
	end

	// ==========================================
	// Sample source
	logic [BUS_W-1:0] sampleBase;
	wire logic [BUS_W-1:0] sampleStep = (modeCfg == FOUR_BUS_SINGLE_CHANNEL) ? 12'h004 :
		(modeCfg == TWO_BUS_PER_CHANNEL) ? 12'h002 : 12'h001;

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			sampleBase <= '0;
		else if (halfTick)
			sampleBase <= sampleBase + sampleStep;
	end

	// ==========================================
	// Bus drivers; one divider keeps skew near zero
	for (genvar k = 0; k < NUM_BUS; k++)
	begin : g_bus
		wire logic [BUS_W-1:0] raw    = constCfg ? patternReg : sampleBase + laneOffset(modeCfg, k);
		wire logic [BUS_W-1:0] placed = raw << lsbIdx;

		lvds_bus_driver #(
			.WIDTH       (BUS_W)
		) u_drv (
			.sys_clk     (sys_clk),
			.reset       (reset),
			.tick        (halfTick),
			.risingEdge  (risingEdge),
			.enable      (enCfg & busOn(modeCfg, k)),
			.sample      (placed),
			.lsbIdx      (lsbIdx),
			.lsbMode     (lsbCfg),
			.lsbZero     (lsbZero),
			.strobeOnLsb (strobeOnLsb),
			.strobeNow   (strobeNow),
			.busClk      (busClk[k]),
			.busData     (busData[k*BUS_W +: BUS_W]),
			.busStrobe   (busStrobe[k])
		);
	end
endmodule

// file: verif/lvds_host_ctrl_props.sv
`timescale 1ns/1ps
module lvds_host_ctrl_props
	import lvds_host_pkg::*;
#(
	parameter int LINK_HALF = 4
)(
	input wire logic                                                sys_clk,
	input wire logic                                                reset,
	input wire logic                                                psel,
	input wire logic                                                penable,
	input wire logic                                                pwrite,
	input wire logic [lvds_host_pkg::APB_AW-1:0]                    paddr,
	input wire logic [lvds_host_pkg::APB_DW-1:0]                    pwdata,
	input wire logic [lvds_host_pkg::APB_DW-1:0]                    prdata,
	input wire logic                                                pready,
	input wire logic                                                pslverr,
	input wire logic                                                alarmPin,
	input wire logic [lvds_host_pkg::NUM_BUS-1:0]                   busClk,
	input wire logic [lvds_host_pkg::NUM_BUS*lvds_host_pkg::BUS_W-1:0] busData,
	input wire logic [lvds_host_pkg::NUM_BUS-1:0]                   busStrobe,
	input wire logic                                                syncPin,
	input wire logic [lvds_host_pkg::DLY_W-1:0]                     fifoReadDelay
);
	// ==========================================
	// Bus handshake and link framing
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_ready_access: assert property (psel && !penable |=> pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_err_ready: assert property (pslverr |-> pready) else $error("pslverr outside access");
	a_rdata_idle: assert property (!pready |-> prdata == '0) else $error("prdata not idle");
	a_strobe_rise: assert property ($rose(busStrobe[0]) |-> $rose(busClk[0])) else $error("strobe off edge");
	// Truncation by reconfiguration still ends low, so this stays safe
	a_strobe_half: assert property ($rose(busStrobe[0]) |-> ##LINK_HALF (!busStrobe[0] && !busClk[0]))
		else $error("strobe length wrong");
	a_strobe_align: assert property (busStrobe[0] == busStrobe[2] && busStrobe[1] == busStrobe[3])
		else $error("strobes misaligned");
	a_lsb_quiet: assert property (!syncPin |-> busStrobe == '0) else $error("dedicated strobe active");
	a_clk_pair: assert property (busClk[0] == busClk[2] && busClk[1] == busClk[3])
		else $error("bus clocks differ");
endmodule
bind lvds_host_ctrl lvds_host_ctrl_props #(.LINK_HALF(LINK_HALF)) u_props (.sys_clk(sys_clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .alarmPin(alarmPin), .busClk(busClk), .busData(busData),
	.busStrobe(busStrobe), .syncPin(syncPin), .fifoReadDelay(fifoReadDelay));

// file: verif/lvds_device_model.sv
`timescale 1ns/1ps
module lvds_device_model (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic [3:0]  busClk,
	input wire logic [47:0] busData,
	input wire logic [3:0]  busStrobe,
	input wire logic        syncPin,
	input wire logic        lsbSel,
	input wire logic [3:0]  laneIdx,
	input wire logic        faultReq,
	output logic            alarmPin,
	output logic [7:0]      strobeGap
);
	// ==========================================
	// Bus A capture, strobe and alarm
	logic        clkPrev;
	logic [11:0] dataPrev;
	logic [7:0]  wrPtr;
	wire         rise   = busClk[0] && !clkPrev;
	wire         lsbUse = !syncPin || lsbSel;
	// Dedicated strobe ignored in LSB use, so a wrong lane shows as a wrong gap
	wire         strobe = lsbUse ? busData[laneIdx] : busStrobe[0];
	always_ff @(posedge sys_clk or posedge reset)
		if (reset)
		begin
			clkPrev   <= 1'b0;
			dataPrev  <= 12'h000;
			wrPtr     <= 8'h00;
			strobeGap <= 8'h00;
			alarmPin  <= 1'b0;
		end
		else
		begin
			clkPrev <= busClk[0];
			if (rise)
			begin
				dataPrev <= busData[11:0];
				wrPtr    <= strobe ? 8'h01 : wrPtr + 8'h01;
				if (strobe)
					strobeGap <= wrPtr;
				alarmPin <= faultReq && (busData[11:0] != dataPrev);
			end
		end
endmodule

// file: verif/lvds_input_fifo_alignment_test.sv
`timescale 1ns/1ps
module lvds_input_fifo_alignment_test;
	import lvds_host_pkg::*;
	// ==========================================
	// Stimulus and observation
	localparam int LH = 2;
	logic        sys_clk = 1'b0;
	logic        reset   = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic        faultReq = 1'b0;
	logic        lsbSel  = 1'b0;
	logic [3:0]  laneIdx = 4'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        alarmPin;
	logic [3:0]  busClk;
	logic [47:0] busData;
	logic [3:0]  busStrobe;
	logic        syncPin;
	logic [4:0]  fifoReadDelay;
	logic [7:0]  strobeGap;
	int          n_fail = 0;
	int          n_compared = 0;
	always #2.5 sys_clk = ~sys_clk;
	lvds_host_ctrl #(.LINK_HALF(LH)) dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.alarmPin(alarmPin), .busClk(busClk), .busData(busData), .busStrobe(busStrobe), .syncPin(syncPin),
		.fifoReadDelay(fifoReadDelay));
	lvds_device_model model (.sys_clk(sys_clk), .reset(reset), .busClk(busClk), .busData(busData),
		.busStrobe(busStrobe), .syncPin(syncPin), .lsbSel(lsbSel), .laneIdx(laneIdx), .faultReq(faultReq),
		.alarmPin(alarmPin), .strobeGap(strobeGap));
	// ==========================================
	// Shared tasks
	task automatic complete_run;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Entered just after a rising edge; the slave's wait is not assumed
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Ends when pready is high; only the watchdog ends a wait that never sees pready
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, exp);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset;
		logic [31:0] r;
		logic        e;
		rdc(OFF_CTRL, 32'(CTRL_RST));
		rdc(OFF_PERIOD, 32'(PERIOD_RST));
		rdc(OFF_WIDTH, 32'(WIDTH_RST));
		rdc(OFF_DELAY, 32'(DELAY_RST));
		rdc(OFF_PATTERN, 32'(PATTERN_RST));
		apb(1'b0, 8'h1c, 32'h0, r, e);
		check({31'h0, e}, 32'h1);
		check(r, 32'h0);
		check({31'h0, syncPin}, 32'h1);
		$display("reset test done");
	endtask
	task automatic t_range;
		logic [31:0] ctl [4] = '{32'h4, 32'h2, 32'h0, 32'h20};
		logic [31:0] mx [4] = '{32'h1f, 32'h0f, 32'h07, 32'h0f};
		for (int i = 0; i < 4; i++)
		begin
			wr(OFF_CTRL, ctl[i]);
			wr(OFF_DELAY, 32'h1f);
			rdc(OFF_DELAY, mx[i]);
			check({27'h0, fifoReadDelay}, mx[i]);
		end
		$display("range test done");
	endtask
	task automatic t_modes;
		logic [3:0]  msk [4] = '{4'h5, 4'hf, 4'hf, 4'h0};
		logic [3:0]  seen;
		logic [11:0] df;
		for (int i = 0; i < 4; i++)
		begin
			wr(OFF_CTRL, 32'h1 | (32'(i) << CTRL_MODE));
			seen = 4'h0;
			repeat (20) @(posedge sys_clk) seen |= busClk;
			check({28'h0, seen}, {28'h0, msk[i]});
			df = busData[47:36] - busData[11:0];
			if (i == 1 || i == 2)
				check({20'h0, df}, (i == 1) ? 32'h1 : 32'h3);
		end
		$display("mode test done");
	endtask
	task automatic t_alarm;
		wr(OFF_CTRL, 32'h85);
		wr(OFF_DELAY, 32'h5);
		faultReq <= 1'b1;
		repeat (40) @(posedge sys_clk);
		rdc(OFF_STATUS, 32'h0);
		wr(OFF_CTRL, 32'h5);
		repeat (40) @(posedge sys_clk);
		rdc(OFF_STATUS, 32'h3);
		wr(OFF_STEP, 32'h0);
		rdc(OFF_DELAY, 32'h4);
		faultReq <= 1'b0;
		repeat (20) @(posedge sys_clk);
		wr(OFF_STEP, 32'h0);
		wr(OFF_STEP, 32'h0);
		rdc(OFF_DELAY, 32'h4);
		wr(OFF_DELAY, 32'h1f);
		wr(OFF_STEP, 32'h0);
		rdc(OFF_DELAY, 32'h0);
		rdc(OFF_STATUS, 32'h0);
		$display("alarm test done");
	endtask
	task automatic t_strobe;
		wr(OFF_PERIOD, 32'h2);
		wr(OFF_CTRL, 32'h45);
		repeat (150) @(posedge sys_clk);
		check({24'h0, strobeGap}, 32'h8);
		laneIdx <= 4'h2;
		lsbSel <= 1'b1;
		wr(OFF_WIDTH, 32'ha);
		wr(OFF_PERIOD, 32'h1);
		wr(OFF_CTRL, 32'h5d);
		repeat (150) @(posedge sys_clk);
		check({24'h0, strobeGap}, 32'h4);
		check({31'h0, syncPin}, 32'h1);
		lsbSel <= 1'b0;
		// New period so a stale gap cannot pass
		wr(OFF_PERIOD, 32'h2);
		wr(OFF_CTRL, 32'h4d);
		repeat (150) @(posedge sys_clk);
		check({31'h0, syncPin}, 32'h0);
		check({24'h0, strobeGap}, 32'h8);
		$display("strobe test done");
	endtask
	initial
	begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		t_reset;
		t_range;
		t_modes;
		t_alarm;
		t_strobe;
		complete_run;
	end
	// Whole run needs about 4 us
	initial
	begin
		#100us;
		n_fail++;
		complete_run;
	end
endmodule
